// *** brake_ovl_regs.svh ***
`ifndef BRAKE_OVL_REGS_SVH
`define BRAKE_OVL_REGS_SVH
// Register offsets (register index = byte offset / 4)
`define OFS_BRAKE_LEVEL    8'h00
`define OFS_SUPPLY_CLASS   8'h04
`define OFS_OVL_FULL       8'h08
`define OFS_OVL_HALF       8'h0c
`define OFS_OVL_LOW        8'h10
`define OFS_ALARM_THR      8'h14
`define OFS_INV_RATED      8'h18
`define OFS_PROT_MASK      8'h1c
`define OFS_MOTOR_LEVEL    8'h20
`define OFS_SWITCH_LEVEL   8'h24
`define OFS_STATUS         8'h28
`define OFS_FAULT_CLEAR    8'h2c
// Reset values
`define RST_BRAKE_LEVEL    16'd375
`define RST_ALARM_THR      8'd85
`define RST_PROT_MASK      16'h0003
`define RST_INV_RATED      16'd100
`define RST_OVL_FULL       16'd110
`define RST_OVL_HALF       16'd100
`define RST_OVL_LOW        16'd80
// Mask bit for switch overload
`define MASK_SWITCH_BIT    1
// Supply bands, volts
`define BAND0_MIN          16'd349
`define BAND0_MAX          16'd410
`define BAND1_MIN          16'd688
`define BAND1_MAX          16'd810
`define BAND2_MIN          16'd850
`define BAND2_MAX          16'd1000
// Speed split points, percent of rated
`define SPEED_LOW_PCT      8'd20
`define SPEED_HALF_PCT     8'd50
// Timing
`define CLK_HZ             64'd40000000
`define MOTOR_TRIP_S       60
`define SWITCH_TRIP_S      3
`define MOTOR_TRIP_CYC     (`CLK_HZ * `MOTOR_TRIP_S)
`define SWITCH_TRIP_CYC    (`CLK_HZ * `SWITCH_TRIP_S)
`endif

// *** brake_ovl_pkg.sv ***
package brake_ovl_pkg;
  typedef struct packed {
    logic [15:0] brake_level;
    logic [1:0]  supply_class;
    logic [15:0] ovl_full;
    logic [15:0] ovl_half;
    logic [15:0] ovl_low;
    logic [7:0]  alarm_thr;
    logic [15:0] inv_rated;
    logic [15:0] prot_mask;
  } cfg_t;
  typedef struct packed {
    logic motor_alarm;
    logic motor_fault;
    logic switch_alarm;
    logic switch_fault;
    logic brake_on;
  } status_t;
  typedef enum logic [2:0] {
    NV_LOAD = 3'b001,
    NV_RUN  = 3'b010,
    NV_SAVE = 3'b100
  } nv_state_t;
endpackage

// *** brake_ovl.sv ***
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "brake_ovl_regs.svh"
module brake_ovl
  import brake_ovl_pkg::*;
#(
  parameter longint MOTOR_TRIP_CYC  = `MOTOR_TRIP_CYC,
  parameter longint SWITCH_TRIP_CYC = `SWITCH_TRIP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Measurements: volts, amps, percent of rated speed
  input  wire logic [15:0] link_voltage_in,
  input  wire logic [15:0] output_current_in,
  input  wire logic [7:0]  speed_pct_in,
  // Non-volatile store of motor integrator
  input  wire logic [31:0] nv_value_in,
  output logic             nv_write_out,
  output logic      [31:0] nv_value_out,
  // Power stage
  output logic             brake_on_out,
  output logic             switches_lock_out,
  output logic             motor_overload_alarm_out,
  output logic             motor_overload_fault_out,
  output logic             switch_overload_alarm_out,
  output logic             switch_overload_fault_out
);

  // Integrator limit: excess (A) * cycles; 150% threshold = 0.5*thr excess
  localparam int ACC_W = 64;

  // Keeps the saved copy inside the 32-bit store at full-length trip times
  localparam int NV_SH = (MOTOR_TRIP_CYC >= 64'd65536) ? 16 : 0;

  cfg_t             cfg_r;
  cfg_t             cfg_nxt;
  logic [ACC_W-1:0] macc_r;
  logic [ACC_W-1:0] macc_nxt;
  logic [ACC_W-1:0] sacc_r;
  logic [ACC_W-1:0] sacc_nxt;
  logic             mfault_r;
  logic             mfault_nxt;
  logic             sfault_r;
  logic             sfault_nxt;
  logic             brake_r;
  logic             brake_nxt;
  nv_state_t        nv_r;
  nv_state_t        nv_nxt;
  logic [15:0]      nv_cnt_r;
  logic [15:0]      nv_cnt_nxt;
  logic [31:0]      rdata_nxt;

  logic [15:0]      eff_min;
  logic [15:0]      eff_max;
  logic [15:0]      eff_level;
  logic [15:0]      thr;
  logic [15:0]      sthr;
  logic             brake_allowed;
  logic             motor_dis;
  logic             switch_en;
  logic [ACC_W-1:0] mlim;
  logic [ACC_W-1:0] slim;
  logic [7:0]       mpct;
  logic [7:0]       spct;
  status_t          status;

  // Level as percent of limit, saturated at 100
  function automatic logic [7:0] pct_of(input logic [ACC_W-1:0] acc,
                                        input logic [ACC_W-1:0] lim);
    logic [ACC_W-1:0] p;
    p = (lim == '0) ? '0 : (acc * 64'd100) / lim;
    pct_of = (p >= 64'd100) ? 8'd100 : p[7:0];
  endfunction

  // One integrator step; decays by threshold/8 plus one per cycle when at or below
  function automatic logic [ACC_W-1:0] integ(input logic [ACC_W-1:0] acc,
                                             input logic [15:0] cur,
                                             input logic [15:0] th);
    logic [ACC_W-1:0] dec;
    dec = {48'h0, 3'h0, th[15:3]} + 64'h1;
    if (cur > th)
      integ = acc + {48'h0, cur - th};
    else
      integ = (acc > dec) ? acc - dec : '0;
  endfunction

  // A full integrator stays at its limit
  function automatic logic [ACC_W-1:0] sat(input logic [ACC_W-1:0] v,
                                           input logic [ACC_W-1:0] lim);
    sat = (v > lim) ? lim : v;
  endfunction

  always_comb begin
    case (cfg_r.supply_class)
      2'd1:    begin eff_min = `BAND1_MIN; eff_max = `BAND1_MAX; end
      2'd2:    begin eff_min = `BAND2_MIN; eff_max = `BAND2_MAX; end
      default: begin eff_min = `BAND0_MIN; eff_max = `BAND0_MAX; end
    endcase
    eff_level = (cfg_r.brake_level < eff_min) ? eff_min : cfg_r.brake_level;
    brake_allowed = cfg_r.brake_level <= eff_max;
    if (speed_pct_in < `SPEED_LOW_PCT)
      thr = cfg_r.ovl_low;
    else if (speed_pct_in <= `SPEED_HALF_PCT)
      thr = cfg_r.ovl_half;
    else
      thr = cfg_r.ovl_full;
    motor_dis = ({1'b0, cfg_r.ovl_full} >= {cfg_r.inv_rated, 1'b0}) &&
                ({1'b0, cfg_r.ovl_half} >= {cfg_r.inv_rated, 1'b0}) &&
                ({1'b0, cfg_r.ovl_low}  >= {cfg_r.inv_rated, 1'b0});
    switch_en = cfg_r.prot_mask[`MASK_SWITCH_BIT];
    // 0.5*thr excess for MOTOR_TRIP_CYC cycles reaches the limit
    mlim = ({48'h0, 1'b0, thr[15:1]} + 64'h1) * 64'(MOTOR_TRIP_CYC);
    // Switch: threshold 150% rated, 200% gives 0.5*rated excess for 3 s
    slim = ({48'h0, 1'b0, cfg_r.inv_rated[15:1]} + 64'h1) * 64'(SWITCH_TRIP_CYC);
    mpct = pct_of(macc_r, mlim);
    spct = pct_of(sacc_r, slim);
  end

  // Switch threshold is 150% of rated; 18 bits keep the product whole
  assign sthr = 16'(({2'b0, cfg_r.inv_rated} * 18'd3) >> 1);

  always_comb begin
    cfg_nxt    = cfg_r;
    macc_nxt   = macc_r;
    sacc_nxt   = sat(integ(sacc_r, output_current_in, sthr), slim);
    mfault_nxt = mfault_r;
    sfault_nxt = sfault_r;
    nv_nxt     = nv_r;
    nv_cnt_nxt = nv_cnt_r;
    brake_nxt  = brake_allowed && (link_voltage_in > eff_level);
    rdata_nxt  = 32'h0;
    case (nv_r)
      NV_LOAD: begin
        macc_nxt = {32'h0, nv_value_in} << NV_SH;
        nv_nxt   = NV_RUN;
      end
      NV_RUN: begin
        macc_nxt   = motor_dis ? '0 : sat(integ(macc_r, output_current_in, thr), mlim);
        nv_cnt_nxt = nv_cnt_r + 16'h1;
        if (nv_cnt_r == 16'hffff)
          nv_nxt = NV_SAVE;
      end
      NV_SAVE: begin
        macc_nxt = motor_dis ? '0 : sat(integ(macc_r, output_current_in, thr), mlim);
        nv_nxt   = NV_RUN;
      end
      default: nv_nxt = NV_LOAD;
    endcase
    if (!motor_dis && mpct >= 8'd100)
      mfault_nxt = 1'b1;
    if (switch_en && spct >= 8'd100)
      sfault_nxt = 1'b1;
    if (wr_in) begin
      case (addr_in)
        `OFS_BRAKE_LEVEL:  cfg_nxt.brake_level  = wdata_in[15:0];
        `OFS_SUPPLY_CLASS: cfg_nxt.supply_class = wdata_in[1:0];
        `OFS_OVL_FULL:     cfg_nxt.ovl_full     = wdata_in[15:0];
        `OFS_OVL_HALF:     cfg_nxt.ovl_half     = wdata_in[15:0];
        `OFS_OVL_LOW:      cfg_nxt.ovl_low      = wdata_in[15:0];
        `OFS_ALARM_THR: begin
          if (wdata_in[7:0] >= 8'd70 && wdata_in[7:0] <= 8'd100)
            cfg_nxt.alarm_thr = wdata_in[7:0];
        end
        `OFS_INV_RATED:    cfg_nxt.inv_rated    = wdata_in[15:0];
        `OFS_PROT_MASK:    cfg_nxt.prot_mask    = wdata_in[15:0];
        // Clear refused while the cause persists: set wins
        `OFS_FAULT_CLEAR: begin
          if (wdata_in[0] && !(mpct >= 8'd100))
            mfault_nxt = 1'b0;
          if (wdata_in[1] && !(spct >= 8'd100))
            sfault_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (!switch_en)
      sfault_nxt = 1'b0;
    if (rd_in) begin
      case (addr_in)
        `OFS_BRAKE_LEVEL:  rdata_nxt = {16'h0, cfg_r.brake_level};
        `OFS_SUPPLY_CLASS: rdata_nxt = {30'h0, cfg_r.supply_class};
        `OFS_OVL_FULL:     rdata_nxt = {16'h0, cfg_r.ovl_full};
        `OFS_OVL_HALF:     rdata_nxt = {16'h0, cfg_r.ovl_half};
        `OFS_OVL_LOW:      rdata_nxt = {16'h0, cfg_r.ovl_low};
        `OFS_ALARM_THR:    rdata_nxt = {24'h0, cfg_r.alarm_thr};
        `OFS_INV_RATED:    rdata_nxt = {16'h0, cfg_r.inv_rated};
        `OFS_PROT_MASK:    rdata_nxt = {16'h0, cfg_r.prot_mask};
        `OFS_MOTOR_LEVEL:  rdata_nxt = {24'h0, mpct};
        `OFS_SWITCH_LEVEL: rdata_nxt = {24'h0, spct};
        `OFS_STATUS:       rdata_nxt = {27'h0, status};
        default:           rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cfg_r     <= '{brake_level: `RST_BRAKE_LEVEL, supply_class: 2'h0,
                     ovl_full: `RST_OVL_FULL, ovl_half: `RST_OVL_HALF,
                     ovl_low: `RST_OVL_LOW, alarm_thr: `RST_ALARM_THR,
                     inv_rated: `RST_INV_RATED, prot_mask: `RST_PROT_MASK};
      macc_r    <= '0;
      sacc_r    <= '0;
      mfault_r  <= 1'b0;
      sfault_r  <= 1'b0;
      brake_r   <= 1'b0;
      nv_r      <= NV_LOAD;
      nv_cnt_r  <= 16'h0;
      rdata_out <= 32'h0;
    end else begin
      cfg_r     <= cfg_nxt;
      macc_r    <= macc_nxt;
      sacc_r    <= sacc_nxt;
      mfault_r  <= mfault_nxt;
      sfault_r  <= sfault_nxt;
      brake_r   <= brake_nxt;
      nv_r      <= nv_nxt;
      nv_cnt_r  <= nv_cnt_nxt;
      rdata_out <= rdata_nxt;
    end
  end

  // Periodic save limits wear on the store at the cost of a stale copy
  assign nv_write_out = (nv_r == NV_SAVE);
  assign nv_value_out = 32'(macc_r >> NV_SH);
  assign brake_on_out = brake_r;
  assign motor_overload_fault_out  = mfault_r;
  assign switch_overload_fault_out = sfault_r;
  assign motor_overload_alarm_out  = (cfg_r.alarm_thr < 8'd100) && !motor_dis &&
                                     (mpct > cfg_r.alarm_thr);
  assign switch_overload_alarm_out = (cfg_r.alarm_thr < 8'd100) && switch_en &&
                                     (spct > cfg_r.alarm_thr);
  assign switches_lock_out = mfault_r || sfault_r;

  always_comb begin
    status.motor_alarm  = motor_overload_alarm_out;
    status.motor_fault  = mfault_r;
    status.switch_alarm = switch_overload_alarm_out;
    status.switch_fault = sfault_r;
    status.brake_on     = brake_r;
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  brake_follow_a: assert property (brake_allowed && link_voltage_in > eff_level
    |=> brake_on_out) else $error("Brake not on above level");
  brake_floor_a: assert property (link_voltage_in <= eff_min
    |=> !brake_on_out) else $error("Brake on below band");
  brake_above_a: assert property (!brake_allowed |=> !brake_on_out)
    else $error("Brake on with level above band");
  lock_fault_a: assert property (motor_overload_fault_out |-> switches_lock_out)
    else $error("Switches not locked on fault");
  no_trip_below_a: assert property (nv_r != NV_LOAD && !mfault_r && mpct < 8'd100
    && output_current_in <= thr |=> !mfault_r) else $error("Fault below threshold");
  alarm_off_a: assert property (cfg_r.alarm_thr == 8'd100 |-> !motor_overload_alarm_out)
    else $error("Alarm with threshold 100");
  trip_full_a: assert property (!motor_dis && mpct >= 8'd100 |=> mfault_r)
    else $error("No fault at full level");
  switch_mask_a: assert property (!switch_en |=> !switch_overload_fault_out)
    else $error("Switch fault while masked");
  nv_restore_a: assert property (rstn_in && nv_r == NV_LOAD
    |=> macc_r == ({32'h0, $past(nv_value_in)} << NV_SH))
    else $error("Integrator not restored");

  // Braking
  brake_raised_a: assert property (cfg_r.brake_level < eff_min && brake_allowed
    && link_voltage_in > eff_min |=> brake_on_out)
    else $error("Raised level does not brake");
  brake_off_a: assert property (link_voltage_in <= eff_level
    |=> !brake_on_out)
    else $error("Brake stays on below level");

  // Threshold choice
  thr_low_a: assert property (speed_pct_in < `SPEED_LOW_PCT
    |-> thr == cfg_r.ovl_low)
    else $error("Low speed threshold not chosen");
  thr_half_a: assert property (speed_pct_in >= `SPEED_LOW_PCT && speed_pct_in <= `SPEED_HALF_PCT
    |-> thr == cfg_r.ovl_half)
    else $error("Half speed threshold not chosen");
  thr_full_a: assert property (speed_pct_in > `SPEED_HALF_PCT
    |-> thr == cfg_r.ovl_full)
    else $error("Full speed threshold not chosen");

  // Integrators
  grow_a: assert property (nv_r != NV_LOAD && !motor_dis && output_current_in > thr
    && macc_r < mlim |=> macc_r > $past(macc_r))
    else $error("Integrator does not grow");
  decay_a: assert property (nv_r != NV_LOAD && !motor_dis && output_current_in <= thr
    && macc_r != '0 |=> macc_r < $past(macc_r))
    else $error("Integrator does not decay");
  motor_off_a: assert property (nv_r != NV_LOAD && motor_dis
    |=> macc_r == '0)
    else $error("Integrator runs while disabled");
  level_read_a: assert property (rd_in && addr_in == `OFS_MOTOR_LEVEL
    |=> rdata_out == {24'h0, $past(mpct)})
    else $error("Motor level read wrong");

  // Faults and alarms
  alarm_over_a: assert property (!motor_dis && cfg_r.alarm_thr < 8'd100
    && mpct > cfg_r.alarm_thr |-> motor_overload_alarm_out)
    else $error("Motor alarm missing");
  salarm_over_a: assert property (switch_en && cfg_r.alarm_thr < 8'd100
    && spct > cfg_r.alarm_thr |-> switch_overload_alarm_out)
    else $error("Switch alarm missing");
  salarm_mask_a: assert property (!switch_en
    |-> !switch_overload_alarm_out)
    else $error("Switch alarm while masked");
  switch_lock_a: assert property (switch_overload_fault_out
    |-> switches_lock_out)
    else $error("Switches not locked on switch fault");
  switch_trip_a: assert property (switch_en && spct >= 8'd100
    |=> sfault_r)
    else $error("No switch fault at full level");
  switch_hold_a: assert property (sfault_r && switch_en
    && !(wr_in && addr_in == `OFS_FAULT_CLEAR && wdata_in[1]) |=> sfault_r)
    else $error("Switch fault dropped");
  switch_below_a: assert property (!sfault_r && spct < 8'd100
    && output_current_in <= sthr |=> !sfault_r)
    else $error("Switch fault below threshold");
  fault_hold_a: assert property (mfault_r
    && !(wr_in && addr_in == `OFS_FAULT_CLEAR && wdata_in[0]) |=> mfault_r)
    else $error("Motor fault dropped");

  // Store
  // Cycles since the last save; saturates so it never wraps back
  logic [16:0] save_gap_r;
  logic [16:0] save_gap_nxt;
  always_comb begin
    save_gap_nxt = (save_gap_r == 17'h1ffff) ? save_gap_r : save_gap_r + 17'h1;
    if (nv_write_out)
      save_gap_nxt = 17'h0;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in)
      save_gap_r <= 17'h0;
    else
      save_gap_r <= save_gap_nxt;
  end
  nv_pulse_a: assert property (nv_write_out
    |=> !nv_write_out)
    else $error("Save strobe too long");
  save_period_a: assert property (save_gap_r <= 17'd65537)
    else $error("Save period exceeded");

  brake_cov: cover property (!brake_on_out ##1 brake_on_out);
  mfault_cov: cover property (!mfault_r ##1 mfault_r);
  salarm_cov: cover property (switch_overload_alarm_out);
  sfault_cov: cover property (!sfault_r ##1 sfault_r);
  restore_cov: cover property (rstn_in && nv_r == NV_LOAD);
endmodule

// *** nv_store.sv ***
`timescale 1ns/1ps
module nv_store #(
  parameter logic [31:0] PRELOAD = 32'h0
) (
  // Clock
  input  wire logic        clk_in,
  // Save port
  input  wire logic        write_in,
  input  wire logic [31:0] value_in,
  // Restore port
  output logic      [31:0] value_out
);
  logic [31:0] mem_r = PRELOAD;
  // Survives the device reset, standing in for a power cycle
  always @(posedge clk_in) begin
    if (write_in) begin
      mem_r <= value_in;
    end
  end
  assign value_out = mem_r;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import brake_ovl_pkg::*;
  localparam longint MT = 100;
  localparam longint ST = 20;
  typedef struct {logic [1:0] c; logic [15:0] l, v; logic e;} row_t;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0]  addr_in = 8'h00, speed_pct_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, nv_in, nv_out, d;
  logic [15:0] link_voltage_in = 16'h0, output_current_in = 16'h0;
  logic        nv_wr, brake_on_out, switches_lock_out, m_alarm, m_fault, s_alarm, s_fault;
  int          error_cnt = 0;
  int          comparisons = 0;
  row_t        rows[10] = '{
    '{0, 16'h0177, 16'h0190, 1}, '{0, 16'h0177, 16'h0172, 0},
    '{0, 16'h0154, 16'h0159, 0}, '{0, 16'h0154, 16'h0160, 1},
    '{0, 16'h01a4, 16'h04b0, 0}, '{1, 16'h02ee, 16'h02ee, 0},
    '{1, 16'h0258, 16'h02a8, 0}, '{1, 16'h02bc, 16'h02c6, 1},
    '{2, 16'h0384, 16'h03b6, 1}, '{2, 16'h044c, 16'h04b0, 0}};
  logic [7:0]  ra[8] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [31:0] rv[8] = '{32'h177, 32'h6e, 32'h64, 32'h50, 32'h55, 32'h64, 32'h3, 32'h0};
  always #12.5 ref_clk_in = ~ref_clk_in;
  brake_ovl #(.MOTOR_TRIP_CYC(MT), .SWITCH_TRIP_CYC(ST)) uut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link_voltage_in(link_voltage_in),
    .output_current_in(output_current_in), .speed_pct_in(speed_pct_in),
    .nv_value_in(nv_in), .nv_write_out(nv_wr), .nv_value_out(nv_out),
    .brake_on_out(brake_on_out), .switches_lock_out(switches_lock_out),
    .motor_overload_alarm_out(m_alarm), .motor_overload_fault_out(m_fault),
    .switch_overload_alarm_out(s_alarm), .switch_overload_fault_out(s_fault));
  // Holds an integrator near 93 percent of the low-speed limit
  nv_store #(.PRELOAD(32'h0000_0ed8)) nvm (
    .clk_in(ref_clk_in), .write_in(nv_wr), .value_in(nv_out), .value_out(nv_in));
  task check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // Limit over excess, rounded up, is the expected time to the fault
  task trip(input int spd, input int cur, input int thr, input int lim, input logic al,
            input logic sw);
    int n, at, e;
    at = -1;
    e = (lim + cur - thr - 1) / (cur - thr);
    @(posedge ref_clk_in);
    speed_pct_in <= 8'(spd);
    output_current_in <= 16'(cur);
    for (n = 0; n < 3000; n++) begin
      @(posedge ref_clk_in);
      #1;
      if (at < 0 && (sw ? s_alarm : m_alarm) === 1'b1) at = n;
      if ((sw ? s_fault : m_fault) === 1'b1) break;
    end
    check(n >= e - 3 && n <= e + 3, "fault time off");
    check((at >= 0 && at < n) == al, "alarm before fault wrong");
    check(switches_lock_out === 1'b1, "switches not locked");
    if (n == 3000) conclude();
    output_current_in <= 16'h0;
    cyc(700);
    wr(8'h2c, 32'h3);
    cyc(2);
    check(m_fault === 1'b0 && s_fault === 1'b0, "fault not cleared");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    cyc(3);
    check(m_alarm === 1'b1, "integrator not restored");
    rd(8'h20, d);
    check(d >= 32'd90 && d <= 32'd93, "level percent wrong");
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      check(d === rv[i], "reset value wrong");
    end
    wr(8'h14, 32'h45);
    rd(8'h14, d);
    check(d === 32'h55, "out of range alarm level taken");
    cyc(400);
    rd(8'h20, d);
    check(m_alarm === 1'b0 && d === 32'h0, "no decay to zero");
    foreach (rows[i]) begin
      wr(8'h04, 32'(rows[i].c));
      wr(8'h00, 32'(rows[i].l));
      link_voltage_in <= rows[i].v;
      cyc(3);
      check(brake_on_out === rows[i].e, "brake state wrong");
    end
    link_voltage_in <= 16'h0;
    wr(8'h1c, 32'h1);
    trip(60, 165, 110, 56 * MT, 1, 0);
    trip(60, 220, 110, 56 * MT, 1, 0);
    trip(30, 150, 100, 51 * MT, 1, 0);
    trip(20, 150, 100, 51 * MT, 1, 0);
    trip(10, 120, 80, 41 * MT, 1, 0);
    wr(8'h14, 32'h64);
    trip(60, 165, 110, 56 * MT, 0, 0);
    wr(8'h14, 32'h55);
    output_current_in <= 16'd109;
    cyc(400);
    check(m_fault === 1'b0, "motor fault below threshold");
    for (int a = 8; a <= 16; a += 4) wr(8'(a), 32'd200);
    output_current_in <= 16'd199;
    cyc(300);
    check(m_fault === 1'b0, "motor overload not disabled");
    check(s_fault === 1'b0 && s_alarm === 1'b0, "switch fault not masked");
    output_current_in <= 16'h0;
    cyc(100);
    wr(8'h1c, 32'h3);
    trip(60, 200, 150, 51 * ST, 1, 1);
    output_current_in <= 16'd149;
    cyc(300);
    check(s_fault === 1'b0, "switch fault below 150 percent");
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    output_current_in <= 16'h0;
    speed_pct_in <= 8'h00;
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    cyc(3);
    check(m_alarm === 1'b1 && nv_wr === 1'b0, "no restore after reset");
    rd(8'h28, d);
    check(d === 32'h10, "status word wrong");
    cyc(1);
    check(rdata_out === 32'h0, "read data held");
    rd(8'h24, d);
    check(d === 32'h0, "switch level not cleared");
    conclude();
  end
endmodule
